// file: hdl/cb_bridge_pkg.sv
// Shared constants and carrier types for the bridge control register block.
package cb_bridge_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  BRIDGE_CONTROL_OFFSET  = 8'h3E;
    localparam logic [7:0]  SUBSYS_VENDOR_OFFSET   = 8'h40;
    localparam logic [7:0]  SUBSYS_IDENT_OFFSET    = 8'h42;
    localparam logic [7:0]  LEGACY_BASE_OFFSET     = 8'h44;
    localparam logic [7:0]  DWORD_ADDR_MASK        = 8'hFC;

    // ------------------------------------------------------------------
    // Bridge control field positions
    // ------------------------------------------------------------------
    localparam int BC_PARITY_RESPONSE  = 0;
    localparam int BC_SYSERR_FORWARD   = 1;
    localparam int BC_ISA_FILTER       = 2;
    localparam int BC_VGA_FORWARD      = 3;
    localparam int BC_MASTER_ABORT     = 5;
    localparam int BC_CARD_RESET       = 6;
    localparam int BC_IRQ_ROUTE        = 7;
    localparam int BC_WINDOW0_PREFETCHABLE        = 8;
    localparam int BC_WINDOW1_PREFETCHABLE        = 9;
    localparam int BC_WRITE_POST       = 10;
    localparam int LEGACY_BASE_FIXED   = 0;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] BRIDGE_CONTROL_RESET   = 16'h0340;
    localparam logic [15:0] BRIDGE_CONTROL_WMASK   = 16'h07EF;
    localparam logic [15:0] SUBSYS_RESET           = 16'h0000;
    localparam logic [15:0] SUBSYS_WMASK           = 16'hFFFF;
    localparam logic [31:0] LEGACY_BASE_RESET      = 32'h0000_0001;
    localparam logic [31:0] LEGACY_BASE_WMASK      = 32'hFFFF_FFFE;

    // ------------------------------------------------------------------
    // Address ranges used by the forwarding decode
    // ------------------------------------------------------------------
    localparam logic [31:0] VGA_MEM_LOW            = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HIGH           = 32'h000B_FFFF;
    localparam logic [31:0] VGA_IO_MONO_LOW        = 32'h0000_03B0;
    localparam logic [31:0] VGA_IO_MONO_HIGH       = 32'h0000_03BB;
    localparam logic [31:0] VGA_IO_COLOR_LOW       = 32'h0000_03C0;
    localparam logic [31:0] VGA_IO_COLOR_HIGH      = 32'h0000_03DF;
    localparam logic [31:0] ISA_RANGE_LIMIT        = 32'h0000_FFFF;

    // Configuration access from the host bus, one per cycle.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  byteEn;
        logic [31:0] wrData;
    } cfg_req_t;

    // Transaction offered to the forwarding decode.
    typedef struct packed {
        logic        valid;
        logic        isIo;
        logic        isWrite;
        logic        isBurst;
        logic        window;
        logic [31:0] addr;
    } fwd_req_t;

endpackage : cb_bridge_pkg

// file: hdl/cfg_field_reg.sv
// Byte-lane writable register with a per-bit write mask.
`timescale 1ns/1ps
`default_nettype none

module cfg_field_reg #(
    parameter int                 WIDTH     = 16,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0,
    parameter logic [WIDTH-1:0]   WMASK     = '1
) (
    // Clock and control
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               clkEnable,
    // Write port
    input  wire logic               wrEn,
    input  wire logic [WIDTH/8-1:0] byteEn,
    input  wire logic [WIDTH-1:0]   wrData,
    // Stored value
    output logic      [WIDTH-1:0]   value_ff
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (WIDTH % 8 != 0 || WIDTH < 8) begin : g_bad_width
        $error("cfg_field_reg: WIDTH must be a positive multiple of 8");
    end

    logic [WIDTH-1:0] laneMask;
    logic [WIDTH-1:0] nxt_value;

    // Expand byte enables to bits and keep only writable bits.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            laneMask[i] = byteEn[i/8] & WMASK[i];
        end
        nxt_value = (value_ff & ~laneMask) | (wrData & laneMask);
    end

    // Masked bits keep their reset value.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            value_ff <= RESET_VAL;
        end else if (clkEnable && wrEn) begin
            value_ff <= nxt_value;
        end
    end

endmodule : cfg_field_reg
`default_nettype wire

// file: hdl/cb_bridge_ctrl.sv
// Bridge control, subsystem identity and legacy base registers with their effects.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Bridge control bits 15-11 are reserved, read zero and ignore writes.
// - Bit 10 enables posting of burst write data across the socket.
// - Bit 9 marks memory window 1 prefetchable; resets to one.
// - Bit 8 marks memory window 0 prefetchable; resets to one.
// - Bit 7 routes card interrupts to PCI (0) or legacy IRQ (1).
// - Bit 6 drives card reset while set; resets to one.
// - Card reset is also asserted whenever PCI reset is asserted.
// - Bit 5 makes card master aborts signal target abort, and SERR while serrEnable is set.
// - Bridge control bit 4 is reserved and always reads zero.
// - Bit 3 forwards VGA memory accesses, and VGA I/O accesses while bit 2 is clear, to the card bus.
// - Bit 2 blocks ISA-range I/O hitting the top 768 bytes of each 1K.
// - Bit 1 forwards card system errors to PCI SERR while serrEnable is set.
// - Bit 0 reports card parity errors on the parity error output.
// - Subsystem vendor register resets zero, writable only with write enable.
// - Subsystem register resets zero, writable only with write enable.
// - I/O at legacy base hits index port; base plus one hits data port.
// - Legacy base sits at any odd address in I/O space; bit 0 reads one.
module cb_bridge_ctrl
    import cb_bridge_pkg::*;
(
    // Clock, reset and clock enable
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clkEnable,

    // Configuration access
    input  wire cfg_req_t    cfgReq,
    output logic [31:0]      cfgRdData_ff,
    output logic             cfgRdValid_ff,

    // System control and PCI side levels
    input  wire logic        subsystemWriteEnable,
    input  wire logic        pciResetIn,
    input  wire logic        serrEnable,

    // Card side events
    input  wire logic        cardMasterAbort,
    input  wire logic        cardSyserr,
    input  wire logic        cardParityErr,
    input  wire logic        cardIrq,

    // Forwarding decode
    input  wire fwd_req_t    fwdReq,
    output logic             fwdValid_ff,
    output logic             forwardToCard_ff,
    output logic             vgaClaim_ff,
    output logic             isaAliasBlocked_ff,
    output logic             legacyIndexHit_ff,
    output logic             legacyDataHit_ff,
    output logic             prefetchAllowed_ff,
    output logic             postWrite_ff,

    // Error and interrupt requests
    output logic             targetAbortReq_ff,
    output logic             serrReq_ff,
    output logic             cperrAssert_ff,
    output logic             pciIrqReq_ff,
    output logic             legacyIrqReq_ff,

    // Control levels
    output logic             cardResetAsserted,
    output logic             write_post_enable,
    output logic             window0_prefetchable,
    output logic             window1_prefetchable,
    output logic             card_irq_route_select,
    output logic             master_abort_report,
    output logic             vga_forward_enable,
    output logic             isa_alias_filter_enable,
    output logic             card_syserr_forward_enable,
    output logic             card_parity_response_enable
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [15:0] bridgeControl;
    logic [15:0] subsysVendor;
    logic [15:0] subsysIdent;
    logic [31:0] legacyBase;

    // Request decode terms.
    logic [7:0]  dwordAddr;
    logic        hitBridgeDword;
    logic        hitSubsysDword;
    logic        hitLegacyDword;
    logic        subsysWrite;

    // Configuration space is dword addressed; byte enables pick halves.
    assign dwordAddr      = cfgReq.addr & DWORD_ADDR_MASK;
    assign hitBridgeDword = dwordAddr
                          == (BRIDGE_CONTROL_OFFSET & DWORD_ADDR_MASK);
    assign hitSubsysDword = dwordAddr == SUBSYS_VENDOR_OFFSET;
    assign hitLegacyDword = dwordAddr == LEGACY_BASE_OFFSET;

    // Identity registers take writes only while system control allows it.
    assign subsysWrite = cfgReq.wr && hitSubsysDword
                         && subsystemWriteEnable;

    // ------------------------------------------------------------------
    // Register instances
    // ------------------------------------------------------------------

    // Bridge control sits in the upper half of its dword; reserved bits
    // are outside the write mask and so stay zero.
    cfg_field_reg #(
        .WIDTH     (16),
        .RESET_VAL (BRIDGE_CONTROL_RESET),
        .WMASK     (BRIDGE_CONTROL_WMASK)
    ) u_bridge_control (
        .core_clk  (core_clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .wrEn      (cfgReq.wr && hitBridgeDword),
        .byteEn    (cfgReq.byteEn[3:2]),
        .wrData    (cfgReq.wrData[31:16]),
        .value_ff  (bridgeControl)
    );

    // Subsystem vendor identity, lower half of its dword.
    cfg_field_reg #(
        .WIDTH     (16),
        .RESET_VAL (SUBSYS_RESET),
        .WMASK     (SUBSYS_WMASK)
    ) u_subsys_vendor (
        .core_clk  (core_clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .wrEn      (subsysWrite),
        .byteEn    (cfgReq.byteEn[1:0]),
        .wrData    (cfgReq.wrData[15:0]),
        .value_ff  (subsysVendor)
    );

    // Subsystem identity, upper half of the same dword.
    cfg_field_reg #(
        .WIDTH     (16),
        .RESET_VAL (SUBSYS_RESET),
        .WMASK     (SUBSYS_WMASK)
    ) u_subsys_ident (
        .core_clk  (core_clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .wrEn      (subsysWrite),
        .byteEn    (cfgReq.byteEn[3:2]),
        .wrData    (cfgReq.wrData[31:16]),
        .value_ff  (subsysIdent)
    );

    // Legacy base: every bit writable except the fixed bit 0.
    cfg_field_reg #(
        .WIDTH     (32),
        .RESET_VAL (LEGACY_BASE_RESET),
        .WMASK     (LEGACY_BASE_WMASK)
    ) u_legacy_base (
        .core_clk  (core_clk),
        .reset     (reset),
        .clkEnable (clkEnable),
        .wrEn      (cfgReq.wr && hitLegacyDword),
        .byteEn    (cfgReq.byteEn),
        .wrData    (cfgReq.wrData),
        .value_ff  (legacyBase)
    );

    // ------------------------------------------------------------------
    // Control levels
    // ------------------------------------------------------------------

    // Field outputs come straight from the stored control word.
    assign write_post_enable           = bridgeControl[BC_WRITE_POST];
    assign window1_prefetchable        = bridgeControl[BC_WINDOW1_PREFETCHABLE];
    assign window0_prefetchable        = bridgeControl[BC_WINDOW0_PREFETCHABLE];
    assign card_irq_route_select       = bridgeControl[BC_IRQ_ROUTE];
    assign master_abort_report         = bridgeControl[BC_MASTER_ABORT];
    assign vga_forward_enable          = bridgeControl[BC_VGA_FORWARD];
    assign isa_alias_filter_enable     = bridgeControl[BC_ISA_FILTER];
    assign card_syserr_forward_enable  = bridgeControl[BC_SYSERR_FORWARD];
    assign card_parity_response_enable = bridgeControl[BC_PARITY_RESPONSE];

    // Card reset follows bit 6; PCI reset holds it
    // without a clock, even while the clock is gated.
    assign cardResetAsserted = bridgeControl[BC_CARD_RESET]
                             | pciResetIn;

    // ------------------------------------------------------------------
    // Configuration read path
    // ------------------------------------------------------------------
    // Read word of the addressed dword.
    logic [31:0] nxt_rdData;

    // Unmapped dwords and the unimplemented lower half at 3Ch read zero.
    always_comb begin
        nxt_rdData = 32'h0000_0000;
        if (hitBridgeDword) begin
            nxt_rdData = {bridgeControl, 16'h0000};
        end else if (hitSubsysDword) begin
            nxt_rdData = {subsysIdent, subsysVendor};
        end else if (hitLegacyDword) begin
            nxt_rdData = legacyBase;
        end
    end

    // Read data is returned one cycle after the read request.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfgRdData_ff  <= 32'h0000_0000;
            cfgRdValid_ff <= 1'b0;
        end else if (clkEnable) begin
            cfgRdValid_ff <= cfgReq.rd;
            if (cfgReq.rd) begin
                cfgRdData_ff <= nxt_rdData;
            end
        end
    end

    // ------------------------------------------------------------------
    // Forwarding decode
    // ------------------------------------------------------------------
    // Decode terms of the offered cycle.
    logic [31:0] fwdAddr;
    logic        vgaMem;
    logic        vgaIo;
    logic        isaAlias;
    logic        indexHit;
    logic        dataHit;

    // Alias for the offered address.
    assign fwdAddr = fwdReq.addr;

    // VGA frame buffer in memory space and VGA ports in I/O space.
    assign vgaMem = !fwdReq.isIo
                  && fwdAddr >= VGA_MEM_LOW && fwdAddr <= VGA_MEM_HIGH;
    assign vgaIo  = fwdReq.isIo
                  && ((fwdAddr >= VGA_IO_MONO_LOW && fwdAddr <= VGA_IO_MONO_HIGH)
                  ||  (fwdAddr >= VGA_IO_COLOR_LOW && fwdAddr <= VGA_IO_COLOR_HIGH));

    // Top 768 bytes of each 1K block have a nonzero value in bits 9:8.
    assign isaAlias = fwdReq.isIo && fwdAddr <= ISA_RANGE_LIMIT
                    && fwdAddr[9:8] != 2'b00;

    // Index port at the base and data port one above it.
    assign indexHit = fwdReq.isIo
                    && fwdAddr == legacyBase;
    assign dataHit  = fwdReq.isIo
                    && fwdAddr == legacyBase + 32'h0000_0001;

    // Decode results are registered and qualified by the request valid.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fwdValid_ff        <= 1'b0;
            vgaClaim_ff        <= 1'b0;
            isaAliasBlocked_ff <= 1'b0;
            legacyIndexHit_ff  <= 1'b0;
            legacyDataHit_ff   <= 1'b0;
        end else if (clkEnable) begin
            fwdValid_ff        <= fwdReq.valid;
            vgaClaim_ff        <= fwdReq.valid && vga_forward_enable
                                  && (vgaMem || vgaIo);
            isaAliasBlocked_ff <= fwdReq.valid && isa_alias_filter_enable
                                  && isaAlias;
            legacyIndexHit_ff  <= fwdReq.valid && indexHit;
            legacyDataHit_ff   <= fwdReq.valid && dataHit;
        end
    end

    // A VGA claim forwards unless it is an ISA alias hit with the filter bit set; such hits never reach the card.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            forwardToCard_ff <= 1'b0;
        end else if (clkEnable) begin
            forwardToCard_ff <= fwdReq.valid
                                && vga_forward_enable && (vgaMem || vgaIo)
                                && !(isa_alias_filter_enable && isaAlias);
        end
    end

    // Memory reads may prefetch only through a prefetchable window.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prefetchAllowed_ff <= 1'b0;
        end else if (clkEnable) begin
            prefetchAllowed_ff <= fwdReq.valid && !fwdReq.isIo && !fwdReq.isWrite
                                  && (fwdReq.window ? window1_prefetchable
                                                    : window0_prefetchable);
        end
    end

    // Only burst writes are posted; single writes complete unposted.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            postWrite_ff <= 1'b0;
        end else if (clkEnable) begin
            postWrite_ff <= fwdReq.valid && fwdReq.isWrite && fwdReq.isBurst
                            && write_post_enable;
        end
    end

    // ------------------------------------------------------------------
    // Error reporting
    // ------------------------------------------------------------------
    // Causes gated by their enable bits.
    logic abortReported;
    logic syserrForward;

    assign abortReported = cardMasterAbort && master_abort_report;
    assign syserrForward = cardSyserr && card_syserr_forward_enable;

    // One-cycle requests toward the PCI target and SERR logic.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            targetAbortReq_ff <= 1'b0;
            serrReq_ff        <= 1'b0;
            cperrAssert_ff    <= 1'b0;
        end else if (clkEnable) begin
            targetAbortReq_ff <= abortReported;
            serrReq_ff        <= serrEnable
                                 && (abortReported || syserrForward);
            cperrAssert_ff    <= cardParityErr
                                 && card_parity_response_enable;
        end
    end

    // ------------------------------------------------------------------
    // Card interrupt routing
    // ------------------------------------------------------------------

    // The card interrupt goes to exactly one destination.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pciIrqReq_ff    <= 1'b0;
            legacyIrqReq_ff <= 1'b0;
        end else if (clkEnable) begin
            pciIrqReq_ff    <= cardIrq && !card_irq_route_select;
            legacyIrqReq_ff <= cardIrq && card_irq_route_select;
        end
    end

endmodule : cb_bridge_ctrl
`default_nettype wire

// file: bench/cb_bridge_ctrl_props.sv
// Concurrent checks on the ports of the bridge control block.
`timescale 1ns/1ps
`default_nettype none
module cb_bridge_ctrl_props
    import cb_bridge_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clkEnable,
    // Causes
    input wire cfg_req_t    cfgReq,
    input wire logic        pciResetIn,
    input wire logic        serrEnable,
    input wire logic        cardMasterAbort,
    input wire logic        cardSyserr,
    input wire logic        cardParityErr,
    input wire logic        cardIrq,
    input wire fwd_req_t    fwdReq,
    // Effects
    input wire logic        cfgRdValid_ff,
    input wire logic [31:0] cfgRdData_ff,
    input wire logic        forwardToCard_ff,
    input wire logic        isaAliasBlocked_ff,
    input wire logic        targetAbortReq_ff,
    input wire logic        serrReq_ff,
    input wire logic        cperrAssert_ff,
    input wire logic        pciIrqReq_ff,
    input wire logic        legacyIrqReq_ff,
    input wire logic        cardResetAsserted,
    // Control fields
    input wire logic        card_irq_route_select,
    input wire logic        master_abort_report,
    input wire logic        isa_alias_filter_enable,
    input wire logic        card_syserr_forward_enable,
    input wire logic        card_parity_response_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // Bridge dword read and its answer.
    sequence bcRead;
        clkEnable && cfgReq.rd && cfgReq.addr[7:2] == 6'h0F;
    endsequence
    sequence bcAnswer;
        cfgRdValid_ff && cfgRdData_ff[31:27] == 5'h00 && !cfgRdData_ff[20];
    endsequence
    // ISA alias cycle with the filter on.
    sequence isaAlias;
        clkEnable && fwdReq.valid && fwdReq.isIo && fwdReq.addr[31:16] == 16'h0000
            && fwdReq.addr[9:8] != 2'h0 && isa_alias_filter_enable;
    endsequence

    bc_reserved_a: assert property (bcRead |=> bcAnswer)
        else $error("reserved bits set");
    prst_reset_a: assert property (pciResetIn |-> cardResetAsserted)
        else $error("card reset missing");
    abort_report_a: assert property (clkEnable |=>
        targetAbortReq_ff == $past(cardMasterAbort && master_abort_report))
        else $error("target abort wrong");
    syserr_fwd_a: assert property (clkEnable && cardSyserr && serrEnable
        && card_syserr_forward_enable |=> serrReq_ff)
        else $error("syserr lost");
    syserr_block_a: assert property (clkEnable && cardSyserr && !cardMasterAbort
        && !card_syserr_forward_enable |=> !serrReq_ff)
        else $error("syserr leaked");
    parity_resp_a: assert property (clkEnable |=>
        cperrAssert_ff == $past(cardParityErr && card_parity_response_enable))
        else $error("parity error response wrong");
    irq_route_a: assert property (clkEnable && cardIrq |=>
        legacyIrqReq_ff == $past(card_irq_route_select) && pciIrqReq_ff != legacyIrqReq_ff)
        else $error("irq route wrong");
    isa_block_a: assert property (isaAlias |=> isaAliasBlocked_ff && !forwardToCard_ff)
        else $error("alias not blocked");
endmodule : cb_bridge_ctrl_props

bind cb_bridge_ctrl cb_bridge_ctrl_props u_props (.*);
`default_nettype wire

// file: bench/host_cfg_model.sv
// Host side model that issues configuration reads and writes.
`timescale 1ns/1ps
`default_nettype none
module host_cfg_model
    import cb_bridge_pkg::*;
(
    // Clock
    input  wire logic        core_clk,
    // Request and answer
    output cfg_req_t         cfgReq,
    input  wire logic        cfgRdValid_ff,
    input  wire logic [31:0] cfgRdData_ff
);
    // Idle: qualifiers carry junk, only strobes count.
    initial cfgReq = '{1'b0, 1'b0, 8'hFF, 4'h0, 32'hDEAD_BEEF};

    // One write strobe, then qualifiers inverted.
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk);
        cfgReq <= '{1'b0, 1'b1, a, be, d};
        @(posedge core_clk);
        cfgReq <= '{1'b0, 1'b0, ~a, ~be, ~d};
    endtask : cfg_write

    // One read strobe; the answer is checked once.
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic ok);
        ok = 1'b0;
        d = 32'h0000_0000;
        @(posedge core_clk);
        cfgReq <= '{1'b1, 1'b0, a, 4'hF, 32'h0000_0000};
        @(posedge core_clk);
        cfgReq <= '{1'b0, 1'b0, ~a, 4'h0, 32'hFFFF_FFFF};
        #1;
        if (cfgRdValid_ff === 1'b1) begin
            ok = 1'b1;
            d = cfgRdData_ff;
        end
    endtask : cfg_read
endmodule : host_cfg_model
`default_nettype wire

// file: bench/tb_cardbus_bridge_control_regs.sv
// Self-checking bench for the bridge control register block.
`timescale 1ns/1ps
`default_nettype none
module tb_cardbus_bridge_control_regs
    import cb_bridge_pkg::*;
;
    // Stimulus
    logic core_clk, reset, clkEnable, subsystemWriteEnable, pciResetIn, serrEnable;
    logic cardMasterAbort, cardSyserr, cardParityErr, cardIrq;
    cfg_req_t cfgReq;
    fwd_req_t fwdReq;
    // Observed
    logic [31:0] cfgRdData_ff;
    logic cfgRdValid_ff, fwdValid_ff, forwardToCard_ff, vgaClaim_ff, isaAliasBlocked_ff;
    logic legacyIndexHit_ff, legacyDataHit_ff, prefetchAllowed_ff, postWrite_ff;
    logic targetAbortReq_ff, serrReq_ff, cperrAssert_ff, pciIrqReq_ff, legacyIrqReq_ff;
    logic cardResetAsserted, write_post_enable, window0_prefetchable, window1_prefetchable;
    logic card_irq_route_select, master_abort_report, vga_forward_enable;
    logic isa_alias_filter_enable, card_syserr_forward_enable, card_parity_response_enable;
    int   err_count, total_checks;

    // Control levels laid out as the bridge control word.
    wire logic [31:0] ctlWord = {21'h0, write_post_enable, window1_prefetchable,
        window0_prefetchable, card_irq_route_select, cardResetAsserted, master_abort_report,
        1'b0, vga_forward_enable, isa_alias_filter_enable, card_syserr_forward_enable,
        card_parity_response_enable};

    cb_bridge_ctrl u_dut (.*);
    host_cfg_model u_host (.*);

    // Clock at 40 MHz.
    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // Counts and reports mismatches.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Counts, verdict, end of run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // Read; no answer ends the run.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic        ok;
        u_host.cfg_read(a, d, ok);
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD answer expected 1 seen %b", ok);
            conclude();
        end else begin
            chk("read", e, d);
        end
    endtask : rdc

    // One decode cycle, then its verdict.
    task automatic fw(input fwd_req_t r, input logic [7:0] e);
        @(posedge core_clk);
        fwdReq <= r;
        @(posedge core_clk);
        fwdReq <= '0;
        #1;
        chk("decode", {24'h00_0000, e}, {24'h00_0000, fwdValid_ff, forwardToCard_ff,
            vgaClaim_ff, isaAliasBlocked_ff, legacyIndexHit_ff, legacyDataHit_ff,
            prefetchAllowed_ff, postWrite_ff});
    endtask : fw

    // One event pulse, then the requests.
    task automatic ev(input logic [3:0] v, input logic [4:0] e);
        @(posedge core_clk);
        {cardMasterAbort, cardSyserr, cardParityErr, cardIrq} <= v;
        @(posedge core_clk);
        {cardMasterAbort, cardSyserr, cardParityErr, cardIrq} <= 4'h0;
        #1;
        chk("event", {27'h000_0000, e}, {27'h000_0000, targetAbortReq_ff, serrReq_ff,
            cperrAssert_ff, pciIrqReq_ff, legacyIrqReq_ff});
    endtask : ev

    // Main sequence.
    initial begin
        err_count = 0;
        total_checks = 0;
        {reset, clkEnable, subsystemWriteEnable, pciResetIn, serrEnable} = 5'h19;
        {cardMasterAbort, cardSyserr, cardParityErr, cardIrq} = 4'h0;
        fwdReq = '0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rdc(8'h3C, 32'h0340_0000);
        chk("ctl", 32'h0000_0340, ctlWord);
        rdc(8'h40, 32'h0000_0000);
        rdc(8'h44, 32'h0000_0001);
        u_host.cfg_write(8'h3C, 4'hF, 32'hFFFF_FFFF);
        rdc(8'h3C, 32'h07EF_0000);
        chk("ctl", 32'h0000_07EF, ctlWord);
        fw('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h000A_0000}, 8'hE2);
        fw('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0100}, 8'h90);
        fw('{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 32'h1000_0000}, 8'h81);
        fw('{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1000_0000}, 8'h82);
        ev(4'h8, 5'h18);
        ev(4'h4, 5'h08);
        ev(4'h2, 5'h04);
        ev(4'h1, 5'h01);
        @(posedge core_clk) serrEnable <= 1'b0;
        ev(4'h8, 5'h10);
        @(posedge core_clk) serrEnable <= 1'b1;
        u_host.cfg_write(8'h3C, 4'hC, 32'h0000_0000);
        #1;
        chk("ctl", 32'h0000_0000, ctlWord);
        @(posedge core_clk);
        pciResetIn <= 1'b1;
        #1;
        chk("crst", 32'h0000_0001, {31'h0, cardResetAsserted});
        @(posedge core_clk);
        pciResetIn <= 1'b0;
        ev(4'hE, 5'h00);
        ev(4'h1, 5'h02);
        fw('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h000A_0000}, 8'h80);
        u_host.cfg_write(8'h40, 4'hF, 32'hA5C3_1E96);
        rdc(8'h40, 32'h0000_0000);
        @(posedge core_clk);
        subsystemWriteEnable <= 1'b1;
        u_host.cfg_write(8'h40, 4'h7, 32'hA5C3_1E96);
        rdc(8'h40, 32'h00C3_1E96);
        u_host.cfg_write(8'h44, 4'hF, 32'h0000_03E0);
        rdc(8'h44, 32'h0000_03E1);
        fw('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_03E1}, 8'h88);
        fw('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_03E2}, 8'h84);
        rdc(8'h50, 32'h0000_0000);
        conclude();
    end
endmodule : tb_cardbus_bridge_control_regs
`default_nettype wire
